/* File: design/mlc_regs.svh */
`ifndef MLC_REGS_SVH
`define MLC_REGS_SVH
// What this block does
// - Single device gates external telegram by setting.
// - External-motion light switches off once detection ends and the delay elapses.
// - All brightness-independent: every motion sends or retriggers.
// - Main-only twilight gates extension motion.
// - Main-only: discard extension motion when bright.
// - Both twilight: accepted motion starts or retriggers.
// - After switch-on evaluate independently until delay ends.
// - Main forces extensions independent, then releases them; while its own override is set the main sends the actuator telegram but no override telegram.
// - Own motion sends ON only below twilight.
// - Override ON makes extension brightness-independent.
// - Delay elapsed: main sends OFF to actuator.
// - Override OFF returns extension brightness-dependent.
// - Extension in dark sends motion telegrams cyclically.
// - Extension stops telegrams when motion ends.
// - Main treats extension motion as detection, sends ON.
// - Delay starts once all extension telegrams cease.
// - Override one disables, zero enables; no auto-revert.

`define MLC_OFS_CTRL 8'h00
`define MLC_OFS_DELAY 8'h04
`define MLC_OFS_WINDOW 8'h08
`define MLC_OFS_CYCLE 8'h0c
`define MLC_OFS_STATUS 8'h10

`define MLC_CTRL_ROLE_LSB 0
`define MLC_CTRL_INDEP_BIT 2
`define MLC_CTRL_MAINONLY_BIT 3
`define MLC_CTRL_EXTINDEP_BIT 4

`define MLC_CTRL_RST 5'h01
`define MLC_DELAY_RST 32'h0000_1000
`define MLC_WINDOW_RST 32'h0000_0800
`define MLC_CYCLE_RST 32'h0000_0400
`endif

/* File: design/mlc_pkg.sv */
package mlc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_DET = 3'b010,
		ST_RUN = 3'b100
	} mlc_state_t;

	typedef enum logic [1:0] {
		ROLE_SINGLE = 2'h0,
		ROLE_MAIN = 2'h1,
		ROLE_EXT = 2'h2
	} mlc_role_t;

	// One outgoing bus telegram: a one-cycle strobe and its switching value.
	typedef struct packed {
		logic valid;
		logic on;
	} mlc_tel_t;
endpackage

/* File: design/mlc_unit.sv */
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "mlc_regs.svh"
module mlc_unit #(
	parameter int CNT_W = 32
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Sensor and bus receiver levels, asynchronous.
	input wire logic motion_local,
	input wire logic dark_below,
	input wire logic ext_motion_rx,
	input wire logic override_rx_stb,
	input wire logic override_rx_val,
	// Outgoing telegrams.
	output mlc_pkg::mlc_tel_t actuator_tx,
	output mlc_pkg::mlc_tel_t override_tx,
	output mlc_pkg::mlc_tel_t motion_tx
);
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic ext_prev_q;
	logic ovr_prev_q;
	logic [4:0] ctrl_q;
	logic [CNT_W-1:0] cfg_delay_q;
	logic [CNT_W-1:0] cfg_window_q;
	logic [CNT_W-1:0] cfg_cycle_q;
	mlc_pkg::mlc_state_t state_q;
	mlc_pkg::mlc_state_t state_d;
	logic [CNT_W-1:0] dly_q;
	logic [CNT_W-1:0] win_q;
	logic [CNT_W-1:0] cyc_q;
	logic ovr_q;
	logic light_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	mlc_pkg::mlc_tel_t act_q;
	mlc_pkg::mlc_tel_t ovt_q;
	mlc_pkg::mlc_tel_t mot_q;

	// Only the second stage is read; the first stage stays private.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 5'h00;
			sync2_q <= 5'h00;
		end else begin
			sync1_q <= {override_rx_val, override_rx_stb, ext_motion_rx, dark_below, motion_local};
			sync2_q <= sync1_q;
		end
	end

	wire mot_s = sync2_q[0];
	wire dark_s = sync2_q[1];
	wire ext_s = sync2_q[2];
	wire ovs_s = sync2_q[3];
	wire ovv_s = sync2_q[4];
	wire ext_rise = ext_s & ~ext_prev_q;
	wire ovr_rise = ovs_s & ~ovr_prev_q;

	wire mlc_pkg::mlc_role_t role = mlc_pkg::mlc_role_t'(ctrl_q[`MLC_CTRL_ROLE_LSB +: 2]);
	wire cfg_indep = ctrl_q[`MLC_CTRL_INDEP_BIT];
	wire cfg_mainonly = ctrl_q[`MLC_CTRL_MAINONLY_BIT];
	wire cfg_extindep = ctrl_q[`MLC_CTRL_EXTINDEP_BIT];
	wire is_ext = (role == mlc_pkg::ROLE_EXT);
	wire is_main = (role == mlc_pkg::ROLE_MAIN);
	wire active = (state_q != mlc_pkg::ST_IDLE);
	wire ext_pres = (win_q != '0);

	// Once the light is on everything counts regardless of brightness.
	wire eval_free = cfg_indep | ovr_q | active;
	wire own_ok = mot_s & (eval_free | dark_s);
	wire ext_single_ok = ext_pres & (cfg_extindep | eval_free | dark_s);
	wire ext_mainonly_ok = ext_pres & (eval_free | dark_s);
	wire ext_main_ok = cfg_mainonly ? ext_mainonly_ok : ext_pres;
	wire ext_ok = is_main ? ext_main_ok : ext_single_ok;
	wire motion = ~is_ext & (own_ok | ext_ok);
	wire dly_done = (dly_q == '0);
	wire go_on = (state_q == mlc_pkg::ST_IDLE) & motion;
	wire go_off = (state_q == mlc_pkg::ST_RUN) & ~motion & dly_done;
	wire ext_go = is_ext & mot_s & (cfg_indep | ovr_q | dark_s);

	always_comb begin
		state_d = state_q;
		case (state_q)
			mlc_pkg::ST_IDLE: begin
				if (motion) begin
					state_d = mlc_pkg::ST_DET;
				end
			end
			mlc_pkg::ST_DET: begin
				if (!motion) begin
					state_d = mlc_pkg::ST_RUN;
				end
			end
			mlc_pkg::ST_RUN: begin
				if (motion) begin
					state_d = mlc_pkg::ST_DET;
				end else if (dly_done) begin
					state_d = mlc_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = mlc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= mlc_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// The delay counter is reloaded on entry to the run-on state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_q <= '0;
		end else if (state_q == mlc_pkg::ST_DET) begin
			dly_q <= cfg_delay_q;
		end else if (state_q == mlc_pkg::ST_RUN && !dly_done) begin
			dly_q <= dly_q - 1'b1;
		end
	end

	// A fresh telegram restarts the window, so presence only lapses after silence.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_q <= '0;
			ext_prev_q <= 1'b0;
		end else begin
			ext_prev_q <= ext_s;
			if (ext_rise) begin
				win_q <= cfg_window_q;
			end else if (ext_pres) begin
				win_q <= win_q - 1'b1;
			end
		end
	end

	// The override holds until the next telegram; nothing reverts it itself.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovr_q <= 1'b0;
			ovr_prev_q <= 1'b0;
		end else begin
			ovr_prev_q <= ovs_s;
			if (ovr_rise) begin
				ovr_q <= ovv_s;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_q <= '0;
			ovt_q <= '0;
			light_q <= 1'b0;
		end else begin
			act_q.valid <= ~is_ext & (go_on | go_off);
			act_q.on <= go_on;
			// A manually overridden main unit leaves the extensions alone.
			ovt_q.valid <= is_main & ~ovr_q & (go_on | go_off);
			ovt_q.on <= go_on;
			if (go_on) begin
				light_q <= 1'b1;
			end else if (go_off) begin
				light_q <= 1'b0;
			end
		end
	end

	// First telegram goes out at once, then one per interval.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc_q <= '0;
			mot_q <= '0;
		end else begin
			mot_q.valid <= ext_go & (cyc_q == '0);
			mot_q.on <= 1'b1;
			if (!ext_go) begin
				cyc_q <= '0;
			end else if (cyc_q == '0) begin
				cyc_q <= cfg_cycle_q;
			end else begin
				cyc_q <= cyc_q - 1'b1;
			end
		end
	end

	wire setup = psel & ~penable;
	wire wr_en = psel & penable & pwrite & pready_q;
	wire hit_ctrl = (paddr == `MLC_OFS_CTRL);
	wire hit_delay = (paddr == `MLC_OFS_DELAY);
	wire hit_window = (paddr == `MLC_OFS_WINDOW);
	wire hit_cycle = (paddr == `MLC_OFS_CYCLE);
	wire hit_status = (paddr == `MLC_OFS_STATUS);
	wire mapped = hit_ctrl | hit_delay | hit_window | hit_cycle | hit_status;
	wire [31:0] status_w = {26'h0, state_q, ovr_q, ext_pres, light_q};
	wire [31:0] rd_mux = hit_ctrl ? {27'h0, ctrl_q} :
		hit_delay ? 32'(cfg_delay_q) :
		hit_window ? 32'(cfg_window_q) :
		hit_cycle ? 32'(cfg_cycle_q) :
		hit_status ? status_w : 32'h0;

	// Zero wait states: ready rises in the first access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~mapped;
			prdata_q <= (setup & ~pwrite) ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `MLC_CTRL_RST;
			cfg_delay_q <= CNT_W'(`MLC_DELAY_RST);
			cfg_window_q <= CNT_W'(`MLC_WINDOW_RST);
			cfg_cycle_q <= CNT_W'(`MLC_CYCLE_RST);
		end else if (wr_en) begin
			if (hit_ctrl) begin
				ctrl_q <= pwdata[4:0];
			end
			if (hit_delay) begin
				cfg_delay_q <= pwdata[CNT_W-1:0];
			end
			if (hit_window) begin
				cfg_window_q <= pwdata[CNT_W-1:0];
			end
			if (hit_cycle) begin
				cfg_cycle_q <= pwdata[CNT_W-1:0];
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign actuator_tx = act_q;
	assign override_tx = ovt_q;
	assign motion_tx = mot_q;

	a_on_from_idle: assert property (@(posedge pclk) disable iff (!presetn)
		act_q.valid && act_q.on |-> $past(state_q) == mlc_pkg::ST_IDLE)
		else $error("ON telegram not from idle");
	a_off_after_delay: assert property (@(posedge pclk) disable iff (!presetn)
		act_q.valid && !act_q.on |-> $past(state_q) == mlc_pkg::ST_RUN && $past(dly_q) == '0)
		else $error("OFF telegram before delay elapsed");
	a_dark_gate: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == mlc_pkg::ST_IDLE && !is_ext && mot_s && !dark_s && !cfg_indep && !ovr_q && !ext_pres
		|=> !act_q.valid)
		else $error("ON sent while bright");
	a_main_discard: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == mlc_pkg::ST_IDLE && is_main && cfg_mainonly && !dark_s && !cfg_indep && !ovr_q
		&& !mot_s |=> state_q == mlc_pkg::ST_IDLE)
		else $error("Extension motion accepted while bright");
	a_delay_start: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == mlc_pkg::ST_DET && !motion |=> state_q == mlc_pkg::ST_RUN && dly_q == $past(cfg_delay_q))
		else $error("Delay not started on silence");
	a_retrigger: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == mlc_pkg::ST_RUN && motion |=> state_q == mlc_pkg::ST_DET ##1 dly_q == $past(cfg_delay_q))
		else $error("Motion did not retrigger delay");
	a_override_follow: assert property (@(posedge pclk) disable iff (!presetn)
		ovr_rise |=> ovr_q == $past(ovv_s))
		else $error("Override did not follow telegram");
	a_force_ext: assert property (@(posedge pclk) disable iff (!presetn)
		act_q.valid && $past(is_main) && !$past(ovr_q) |-> ovt_q.valid && ovt_q.on == act_q.on)
		else $error("Extensions not switched with actuator");
	a_ext_stop: assert property (@(posedge pclk) disable iff (!presetn)
		is_ext && !mot_s |=> !mot_q.valid)
		else $error("Motion telegram after motion ended");
	a_ext_cyclic: assert property (@(posedge pclk) disable iff (!presetn)
		mot_q.valid && cfg_cycle_q > 2 && $stable(cfg_cycle_q) |=> !mot_q.valid [*2])
		else $error("Motion telegrams too close");
	// These watch the synchronised levels, so pin timing cannot make them fire early.
	a_light_track: assert property (@(posedge pclk) disable iff (!presetn)
		act_q.valid |-> light_q == act_q.on)
		else $error("Light flag disagrees with actuator telegram");
	a_state_onehot: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot(state_q))
		else $error("State register not one-hot");
	a_det_hold: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == mlc_pkg::ST_DET && motion |=> state_q == mlc_pkg::ST_DET)
		else $error("Delay started while motion present");
	a_win_reload: assert property (@(posedge pclk) disable iff (!presetn)
		ext_rise |=> win_q == $past(cfg_window_q))
		else $error("Window not restarted by telegram");
	a_win_lapse: assert property (@(posedge pclk) disable iff (!presetn)
		!ext_rise && win_q == CNT_W'(1) |=> !ext_pres)
		else $error("External presence outlived its window");
	a_main_accept: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == mlc_pkg::ST_IDLE && is_main && cfg_mainonly && ext_pres && dark_s
		|=> act_q.valid && act_q.on)
		else $error("Extension motion dropped while dark");
	a_both_accept: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == mlc_pkg::ST_IDLE && is_main && !cfg_mainonly && ext_pres |=> act_q.valid && act_q.on)
		else $error("Accepted extension motion did not switch on");
	a_single_bright: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == mlc_pkg::ST_IDLE && role == mlc_pkg::ROLE_SINGLE && !cfg_extindep && !cfg_indep
		&& !ovr_q && !dark_s |=> !act_q.valid)
		else $error("Single unit switched on while bright");
	a_ovr_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!ovr_rise |=> ovr_q == $past(ovr_q))
		else $error("Override changed without telegram");
	a_ovr_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		ovr_q |=> !ovt_q.valid)
		else $error("Overridden main unit drove extensions");
	a_ext_no_act: assert property (@(posedge pclk) disable iff (!presetn)
		is_ext |=> !act_q.valid && !ovt_q.valid)
		else $error("Extension sent an actuator telegram");
	a_ext_gate: assert property (@(posedge pclk) disable iff (!presetn)
		is_ext && !cfg_indep && !ovr_q && !dark_s |=> !mot_q.valid)
		else $error("Extension sent motion while bright");
	a_ext_first: assert property (@(posedge pclk) disable iff (!presetn)
		ext_go && cyc_q == '0 |=> mot_q.valid && mot_q.on)
		else $error("Motion telegram not sent at once");

	c_main_cycle: cover property (@(posedge pclk) disable iff (!presetn)
		go_on ##[1:1000] go_off);
	c_retrigger: cover property (@(posedge pclk) disable iff (!presetn)
		state_q == mlc_pkg::ST_RUN ##1 state_q == mlc_pkg::ST_DET);
	c_ext_repeat: cover property (@(posedge pclk) disable iff (!presetn)
		mot_q.valid ##[1:1000] mot_q.valid);
	c_mainonly_drop: cover property (@(posedge pclk) disable iff (!presetn)
		state_q == mlc_pkg::ST_IDLE && is_main && cfg_mainonly && ext_pres && !dark_s);
	c_ext_override: cover property (@(posedge pclk) disable iff (!presetn)
		is_ext && ovr_rise ##1 ovr_q);
endmodule

/* File: testbench/mlc_partner.sv */
`timescale 1ns/1ps
// One extension detector plus the switch actuator on the far bus side.
module mlc_partner (
	// Clock.
	input wire logic pclk,
	// Scene seen by the extension.
	input wire logic moving,
	input wire logic ext_dark,
	// Bus traffic.
	input mlc_pkg::mlc_tel_t actuator_tx,
	output logic ext_motion_rx,
	output logic light_q
);
	logic [3:0] cnt_q = 4'h0;
	initial ext_motion_rx = 1'b0;
	initial light_q = 1'b0;
	// The actuator command also reaches the override input, so a lit room means independent.
	always @(posedge pclk) begin
		if (actuator_tx.valid) begin
			light_q <= actuator_tx.on;
		end
		if (moving && (ext_dark || light_q)) begin
			cnt_q <= cnt_q + 4'h1;
			ext_motion_rx <= cnt_q[2];
		end else begin
			cnt_q <= 4'h0;
			ext_motion_rx <= 1'b0;
		end
	end
endmodule

/* File: testbench/motion_light_main_extension_coordination_bench.sv */
`timescale 1ns/1ps
module motion_light_main_extension_coordination_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic motion_local, dark_below, ext_motion_rx, override_rx_stb, override_rx_val, moving, ext_dark, light_q;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	mlc_pkg::mlc_tel_t actuator_tx, override_tx, motion_tx;
	int checks = 0, miscompares = 0, a_on = 0, a_off = 0, o_on = 0, o_off = 0, m_cnt = 0, n, c;

	mlc_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.motion_local(motion_local), .dark_below(dark_below), .ext_motion_rx(ext_motion_rx),
		.override_rx_stb(override_rx_stb), .override_rx_val(override_rx_val),
		.actuator_tx(actuator_tx), .override_tx(override_tx), .motion_tx(motion_tx));
	mlc_partner far_side (.pclk(pclk), .moving(moving), .ext_dark(ext_dark), .actuator_tx(actuator_tx),
		.ext_motion_rx(ext_motion_rx), .light_q(light_q));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Telegram counters; tests compare running totals.
	always @(posedge pclk) begin
		a_on <= a_on + (actuator_tx.valid & actuator_tx.on);
		a_off <= a_off + (actuator_tx.valid & !actuator_tx.on);
		o_on <= o_on + (override_tx.valid & override_tx.on);
		o_off <= o_off + (override_tx.valid & !override_tx.on);
		m_cnt <= m_cnt + (motion_tx.valid & motion_tx.on);
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wt(input int k);
		repeat (k) @(posedge pclk);
	endtask
	// Starts right after a rising edge; pready is sampled at each rising edge, as the slave sees it.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			miscompares++;
			end_of_test;
		end
		rd = prdata;
		err = pslverr;
		// One idle edge after release, so a following call never reassigns these in the same step.
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Waits for a fresh telegram edge so the absence window starts at a known point.
	task automatic rx_rise;
		int k;
		k = 0;
		while (ext_motion_rx === 1'b1 && k < 20) begin
			@(posedge pclk);
			k++;
		end
		while (ext_motion_rx !== 1'b1 && k < 40) begin
			@(posedge pclk);
			k++;
		end
		if (ext_motion_rx !== 1'b1) begin
			miscompares++;
			end_of_test;
		end
	endtask
	task automatic wait_for(ref int cnt, input int target);
		n = 0;
		while (cnt < target && n < 300) begin
			@(posedge pclk);
			n++;
		end
		if (cnt < target) begin
			miscompares++;
			end_of_test;
		end
	endtask
	task automatic ovr(input logic v);
		override_rx_val <= v;
		wt(3);
		override_rx_stb <= 1'b1;
		wt(4);
		override_rx_stb <= 1'b0;
		wt(4);
	endtask

	task automatic test_regs;
		logic [7:0] a [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
		logic [31:0] e [6] = '{32'h1, 32'h1000, 32'h800, 32'h400, 32'h8, 32'h0};
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, a[i], 32'h0);
			chk("read data", e[i], rd);
			chk("slave error", {31'h0, i == 5}, {31'h0, err});
		end
		apb(1'b1, 8'h04, 32'ha);
		apb(1'b1, 8'h08, 32'h14);
		apb(1'b1, 8'h0c, 32'h5);
		apb(1'b0, 8'h04, 32'h0);
		chk("delay", 32'ha, rd);
		$display("registers done");
	endtask
	task automatic test_main;
		apb(1'b1, 8'h00, 32'h1);
		dark_below <= 1'b1;
		motion_local <= 1'b1;
		wait_for(a_on, 1);
		wt(3);
		chk("override on", 1, o_on);
		chk("lamp on", 1, {31'h0, light_q});
		motion_local <= 1'b0;
		wait_for(a_off, 1);
		chk("run on long enough", 1, {31'h0, n >= 10});
		wt(3);
		chk("override off", 1, o_off);
		chk("lamp off", 0, {31'h0, light_q});
		dark_below <= 1'b0;
		motion_local <= 1'b1;
		wt(30);
		chk("bright own motion", 1, a_on);
		apb(1'b1, 8'h00, 32'h5);
		wait_for(a_on, 2);
		motion_local <= 1'b0;
		wait_for(a_off, 2);
		$display("main unit done");
	endtask
	task automatic test_ext_in;
		apb(1'b1, 8'h00, 32'h9);
		ext_dark <= 1'b1;
		moving <= 1'b1;
		wt(40);
		chk("bright extension motion", 2, a_on);
		dark_below <= 1'b1;
		wait_for(a_on, 3);
		rx_rise;
		moving <= 1'b0;
		wait_for(a_off, 3);
		chk("absence plus delay", 1, {31'h0, n >= 30});
		apb(1'b1, 8'h00, 32'h0);
		dark_below <= 1'b0;
		moving <= 1'b1;
		wt(40);
		chk("single gated", 3, a_on);
		apb(1'b1, 8'h00, 32'h10);
		wait_for(a_on, 4);
		moving <= 1'b0;
		wait_for(a_off, 4);
		$display("external motion done");
	endtask
	task automatic test_ext_role;
		apb(1'b1, 8'h00, 32'h2);
		dark_below <= 1'b1;
		motion_local <= 1'b1;
		wait_for(m_cnt, m_cnt + 1);
		c = m_cnt;
		wait_for(m_cnt, c + 1);
		chk("cyclic interval", 6, n);
		motion_local <= 1'b0;
		wt(5);
		c = m_cnt;
		dark_below <= 1'b0;
		wt(20);
		motion_local <= 1'b1;
		wt(20);
		chk("silent when gone or bright", c, m_cnt);
		ovr(1'b1);
		wt(15);
		chk("override sends", 1, {31'h0, m_cnt > c});
		ovr(1'b0);
		wt(10);
		c = m_cnt;
		wt(20);
		chk("override cleared", c, m_cnt);
		$display("extension done");
	endtask

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, motion_local, dark_below, override_rx_stb, override_rx_val} = 7'h0;
		{moving, ext_dark} = 2'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		wt(20);
		presetn <= 1'b1;
		wt(1);
		test_regs;
		test_main;
		test_ext_in;
		test_ext_role;
		end_of_test;
	end
	initial begin
		#400000;
		miscompares++;
		end_of_test;
	end
endmodule
